// ---- design/rpfcb_pkg.sv ----
// Shared constants and types for the regulator power-fail configuration bank
package rpfcb_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] POWER_FAIL_COMPARATOR_CONFIG_OFS = 12'h510;
  localparam logic [ADDR_W-1:0] MAIN_REGULATOR_SWITCHER_ENABLE_OFS = 12'h704;
  localparam logic [ADDR_W-1:0] RADIO_REGULATOR_SWITCHER_ENABLE_OFS = 12'h904;
  localparam logic [ADDR_W-1:0] HIGH_VOLTAGE_REGULATOR_SWITCHER_ENABLE_OFS = 12'hb00;

  // ----------------------------------------
  // Field layout of the comparator and switcher enable registers
  // ----------------------------------------
  localparam int unsigned POWER_FAIL_ENABLE_POS = 0;
  localparam int unsigned LOW_SUPPLY_WARN_LEVEL_LSB = 1;
  localparam int unsigned HIGH_SUPPLY_WARN_LEVEL_LSB = 8;
  localparam int unsigned LEVEL_W = 4;
  localparam int unsigned SWITCHER_ENABLE_POS = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] POWER_FAIL_CONFIG_RESET = 32'h0000_0000;
  localparam logic SWITCHER_ENABLE_RESET = 1'b0;

  // ----------------------------------------
  // Level encodings, in units of 0.1 V
  // ----------------------------------------
  localparam logic [LEVEL_W-1:0] LOW_LEVEL_MIN_CODE = 4'h6;
  localparam logic [5:0] LOW_LEVEL_CODE_OFFSET = 6'h0d;
  localparam logic [5:0] HIGH_LEVEL_CODE_OFFSET = 6'h1b;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [LEVEL_W-1:0] high_supply_warn_level;
    logic [LEVEL_W-1:0] low_supply_warn_level;
    logic power_fail_enable;
  } rpfcb_cfg_t;

  typedef struct packed {
    logic high_voltage_regulator;
    logic radio_regulator;
    logic main_regulator;
  } rpfcb_switcher_t;

  typedef struct packed {
    logic comparator_on;
    logic level_valid;
    logic [5:0] level_tenths_volt;
  } rpfcb_level_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_POWER_FAIL_CONFIG,
    SEL_MAIN_SWITCHER,
    SEL_RADIO_SWITCHER,
    SEL_HIGH_VOLTAGE_SWITCHER
  } rpfcb_sel_t;

endpackage

// ---- design/rpfcb_level_decode.sv ----
// Picks the active warning level for the current supply mode
`timescale 1ns/1ps

module rpfcb_level_decode (
  // Clock and power-on reset
  input wire logic hclk,
  input wire logic por_n,
  // Configuration and mode
  input wire rpfcb_pkg::rpfcb_cfg_t cfg,
  input wire logic high_voltage_mode,
  // Decoded level
  output rpfcb_pkg::rpfcb_level_t level
);

  // ----------------------------------------
  // Level selection
  // ----------------------------------------
  rpfcb_pkg::rpfcb_level_t level_next;

  always_comb begin
    level_next.comparator_on = cfg.power_fail_enable; // [R1]
    if (high_voltage_mode) begin
      // Every high-supply code is a valid level [R3] [R8]
      level_next.level_valid = 1'b1;
      level_next.level_tenths_volt = rpfcb_pkg::HIGH_LEVEL_CODE_OFFSET
                                     + {2'h0, cfg.high_supply_warn_level};
    end else begin
      // Codes below six have no documented level; flagged, not altered [R2] [R8]
      level_next.level_valid = (cfg.low_supply_warn_level >= rpfcb_pkg::LOW_LEVEL_MIN_CODE);
      level_next.level_tenths_volt = rpfcb_pkg::LOW_LEVEL_CODE_OFFSET
                                     + {2'h0, cfg.low_supply_warn_level};
    end
  end

  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      level <= '0;
    end else begin
      level <= level_next;
    end
  end

endmodule

// ---- design/rpfcb_bank.sv ----
// AHB-Lite register bank holding retained power-fail and switcher settings
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps

// What this block does
// (R1) Bit 0 of the comparator register turns the power-fail comparator off or on.
// (R2) Four-bit low-supply warning level; codes 6 to 15 mean 1.9 V to 2.8 V.
// (R3) Four-bit high-supply warning level; codes 0 to 15 mean 2.7 V to 4.2 V.
// (R4) Comparator register at 0x510 survives ordinary resets.
// (R5) Retained register at 0x704 enables switching mode of the main regulator.
// (R6) Retained register at 0x904 enables switching mode of the radio regulator.
// (R7) Retained register at 0xB00 enables switching mode of the high-voltage regulator.
// (R8) High-supply level applies in high voltage mode, low-supply level otherwise.
// (R9) Each regulator starts linear; switching only when its own enable is set.
// (R10) Enable bit 0, low level bits 4:1, high level bits 11:8, rest zero.
module rpfcb_bank (
  // Clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Supply mode
  input wire logic high_voltage_mode,
  // Configuration to the analog side
  output rpfcb_pkg::rpfcb_cfg_t power_fail_config,
  output rpfcb_pkg::rpfcb_switcher_t switcher_enable,
  output rpfcb_pkg::rpfcb_level_t active_level
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic rpfcb_pkg::rpfcb_sel_t decode_sel(input logic [31:0] addr);
    logic [rpfcb_pkg::ADDR_W-1:0] ofs;
    ofs = addr[rpfcb_pkg::ADDR_W-1:0];
    // Upper address bits belong to the interconnect decode; only the window is compared
    if (ofs == rpfcb_pkg::POWER_FAIL_COMPARATOR_CONFIG_OFS) begin
      decode_sel = rpfcb_pkg::SEL_POWER_FAIL_CONFIG;
    end else if (ofs == rpfcb_pkg::MAIN_REGULATOR_SWITCHER_ENABLE_OFS) begin
      decode_sel = rpfcb_pkg::SEL_MAIN_SWITCHER;
    end else if (ofs == rpfcb_pkg::RADIO_REGULATOR_SWITCHER_ENABLE_OFS) begin
      decode_sel = rpfcb_pkg::SEL_RADIO_SWITCHER;
    end else if (ofs == rpfcb_pkg::HIGH_VOLTAGE_REGULATOR_SWITCHER_ENABLE_OFS) begin
      decode_sel = rpfcb_pkg::SEL_HIGH_VOLTAGE_SWITCHER;
    end else begin
      decode_sel = rpfcb_pkg::SEL_NONE;
    end
  endfunction

  // ----------------------------------------
  // Address phase capture
  // ----------------------------------------
  logic addr_phase_valid;
  rpfcb_pkg::rpfcb_sel_t addr_sel;
  logic write_pending_reg;
  rpfcb_pkg::rpfcb_sel_t write_sel_reg;

  assign addr_phase_valid = hsel && hready && htrans[1];
  assign addr_sel = decode_sel(haddr);

  // Bus state follows the ordinary reset, unlike the retained contents
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_pending_reg <= 1'b0;
      write_sel_reg <= rpfcb_pkg::SEL_NONE;
    end else if (hready) begin
      write_pending_reg <= addr_phase_valid && hwrite;
      write_sel_reg <= addr_phase_valid ? addr_sel : rpfcb_pkg::SEL_NONE;
    end
  end

  // ----------------------------------------
  // Zero-wait response
  // ----------------------------------------
  // Every access completes in its first data-phase cycle, so no wait state is ever inserted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= rpfcb_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= rpfcb_pkg::HRESP_OKAY;
    end
  end

  // ----------------------------------------
  // Retained comparator configuration
  // ----------------------------------------
  logic do_write;
  logic cfg_we;
  rpfcb_pkg::rpfcb_cfg_t cfg_next;

  assign do_write = write_pending_reg;
  assign cfg_we = do_write && (write_sel_reg == rpfcb_pkg::SEL_POWER_FAIL_CONFIG);

  always_comb begin
    cfg_next.power_fail_enable = hwdata[rpfcb_pkg::POWER_FAIL_ENABLE_POS]; // [R1] [R10]
    cfg_next.low_supply_warn_level = hwdata[rpfcb_pkg::LOW_SUPPLY_WARN_LEVEL_LSB +:
                                            rpfcb_pkg::LEVEL_W]; // [R2] [R10]
    cfg_next.high_supply_warn_level = hwdata[rpfcb_pkg::HIGH_SUPPLY_WARN_LEVEL_LSB +:
                                             rpfcb_pkg::LEVEL_W]; // [R3] [R10]
  end

  // Cleared only at power-on, ordinary reset leaves it alone [R4]
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      power_fail_config.power_fail_enable <=
        rpfcb_pkg::POWER_FAIL_CONFIG_RESET[rpfcb_pkg::POWER_FAIL_ENABLE_POS]; // [R10]
      power_fail_config.low_supply_warn_level <= rpfcb_pkg::POWER_FAIL_CONFIG_RESET[
        rpfcb_pkg::LOW_SUPPLY_WARN_LEVEL_LSB +: rpfcb_pkg::LEVEL_W];
      power_fail_config.high_supply_warn_level <= rpfcb_pkg::POWER_FAIL_CONFIG_RESET[
        rpfcb_pkg::HIGH_SUPPLY_WARN_LEVEL_LSB +: rpfcb_pkg::LEVEL_W];
    end else if (cfg_we) begin
      power_fail_config <= cfg_next;
    end
  end

  // ----------------------------------------
  // Retained switcher enables
  // ----------------------------------------
  // Index 0 main, 1 radio, 2 high voltage, the bit order of the output struct
  logic [2:0] sw_we;
  logic [2:0] sw_reg;
  logic wr_switch;

  assign wr_switch = hwdata[rpfcb_pkg::SWITCHER_ENABLE_POS];
  assign sw_we = {do_write && (write_sel_reg == rpfcb_pkg::SEL_HIGH_VOLTAGE_SWITCHER),
                  do_write && (write_sel_reg == rpfcb_pkg::SEL_RADIO_SWITCHER),
                  do_write && (write_sel_reg == rpfcb_pkg::SEL_MAIN_SWITCHER)}; // [R5] [R6] [R7]

  // Linear operation after power-on; one write moves only its own enable [R9]
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      sw_reg <= {3{rpfcb_pkg::SWITCHER_ENABLE_RESET}};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (sw_we[i]) begin
          sw_reg[i] <= wr_switch;
        end
      end
    end
  end

  assign switcher_enable = rpfcb_pkg::rpfcb_switcher_t'(sw_reg);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Read data is registered at the address phase; a write whose data phase falls in the address phase
  // of a read of the same register is forwarded into the read data, so the read sees the new value.
  logic [31:0] rdata_next;
  rpfcb_pkg::rpfcb_cfg_t cfg_view;
  logic [2:0] sw_view;

  always_comb begin
    cfg_view = cfg_we ? cfg_next : power_fail_config;
    sw_view = sw_reg;
    for (int i = 0; i < 3; i++) begin
      if (sw_we[i]) begin
        sw_view[i] = wr_switch;
      end
    end
    rdata_next = 32'h0000_0000;
    case (addr_sel)
      rpfcb_pkg::SEL_POWER_FAIL_CONFIG: begin
        rdata_next[rpfcb_pkg::POWER_FAIL_ENABLE_POS] = cfg_view.power_fail_enable; // [R10]
        rdata_next[rpfcb_pkg::LOW_SUPPLY_WARN_LEVEL_LSB +: rpfcb_pkg::LEVEL_W] =
          cfg_view.low_supply_warn_level;
        rdata_next[rpfcb_pkg::HIGH_SUPPLY_WARN_LEVEL_LSB +: rpfcb_pkg::LEVEL_W] =
          cfg_view.high_supply_warn_level;
      end
      rpfcb_pkg::SEL_MAIN_SWITCHER: begin
        rdata_next[rpfcb_pkg::SWITCHER_ENABLE_POS] = sw_view[0];
      end
      rpfcb_pkg::SEL_RADIO_SWITCHER: begin
        rdata_next[rpfcb_pkg::SWITCHER_ENABLE_POS] = sw_view[1];
      end
      rpfcb_pkg::SEL_HIGH_VOLTAGE_SWITCHER: begin
        rdata_next[rpfcb_pkg::SWITCHER_ENABLE_POS] = sw_view[2];
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase_valid && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

  // ----------------------------------------
  // Active level for the comparator
  // ----------------------------------------
  rpfcb_level_decode u_level_decode (
    .hclk(hclk),
    .por_n(por_n),
    .cfg(power_fail_config),
    .high_voltage_mode(high_voltage_mode),
    .level(active_level)
  );

endmodule

// ---- verif/rpfcb_bank_chk.sv ----
// Concurrent checks on the register bank ports
`timescale 1ns/1ps

module rpfcb_bank_chk (
  // Clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Mode and settings
  input wire logic high_voltage_mode,
  input wire rpfcb_pkg::rpfcb_cfg_t power_fail_config,
  input wire rpfcb_pkg::rpfcb_switcher_t switcher_enable,
  input wire rpfcb_pkg::rpfcb_level_t active_level
);
  // ----------------
  // Sequences
  // ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !por_n);

  sequence s_take(logic [11:0] ofs, logic wr);
    hsel && hready && htrans[1] && haddr[11:0] == ofs && hwrite == wr;
  endsequence
  // Address phase, then the data phase edge
  sequence s_wr(logic [11:0] ofs);
    s_take(ofs, 1'b1) ##1 1'b1;
  endsequence

  // ----------------
  // Properties
  // ----------------
  property p_okay;
    hresp == rpfcb_pkg::HRESP_OKAY && hreadyout;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  property p_cfg_wr;
    s_wr(rpfcb_pkg::POWER_FAIL_COMPARATOR_CONFIG_OFS) |=>
      power_fail_config == {$past(hwdata[11:8]), $past(hwdata[4:1]), $past(hwdata[0])};
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("comparator fields not stored");
  property p_cfg_rd;
    s_take(rpfcb_pkg::POWER_FAIL_COMPARATOR_CONFIG_OFS, 1'b0) |=>
      hrdata == {20'h0_0000, power_fail_config[8:5], 3'h0, power_fail_config[4:0]};
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("comparator readback wrong");
  property p_sw_main;
    s_wr(rpfcb_pkg::MAIN_REGULATOR_SWITCHER_ENABLE_OFS) |=>
      switcher_enable.main_regulator == $past(hwdata[0]);
  endproperty
  a_sw_main: assert property (p_sw_main) else $error("main switcher not stored");
  property p_sw_radio;
    s_wr(rpfcb_pkg::RADIO_REGULATOR_SWITCHER_ENABLE_OFS) |=>
      switcher_enable.radio_regulator == $past(hwdata[0]);
  endproperty
  a_sw_radio: assert property (p_sw_radio) else $error("radio switcher not stored");
  property p_sw_high;
    s_wr(rpfcb_pkg::HIGH_VOLTAGE_REGULATOR_SWITCHER_ENABLE_OFS) |=>
      switcher_enable.high_voltage_regulator == $past(hwdata[0]);
  endproperty
  a_sw_high: assert property (p_sw_high) else $error("high switcher not stored");
  // Skip the power-on release edge: the level flop is still cleared there
  property p_lvl_lo;
    por_n && !high_voltage_mode |=> active_level == {$past(power_fail_config[0]),
      $past(power_fail_config[4:1]) >= 4'h6, 6'h0d + {2'h0, $past(power_fail_config[4:1])}};
  endproperty
  a_lvl_lo: assert property (p_lvl_lo) else $error("normal mode level wrong");
  property p_lvl_hi;
    por_n && high_voltage_mode |=> active_level == {$past(power_fail_config[0]), 1'b1,
      6'h1b + {2'h0, $past(power_fail_config[8:5])}};
  endproperty
  a_lvl_hi: assert property (p_lvl_hi) else $error("high mode level wrong");
  property p_rd_hold;
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  // Ordinary reset must leave retained settings alone
  property p_retain;
    disable iff (!por_n) (!hresetn ##1 !hresetn) |->
      $stable(power_fail_config) && $stable(switcher_enable);
  endproperty
  a_retain: assert property (p_retain) else $error("retained setting lost");
endmodule

bind rpfcb_bank rpfcb_bank_chk rpfcb_bank_chk_inst (.hclk, .hresetn, .por_n, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .high_voltage_mode,
  .power_fail_config, .switcher_enable, .active_level);

// ---- verif/rpfcb_bank_test.sv ----
// Self-checking bench for the regulator configuration bank
`timescale 1ns/1ps

module rpfcb_bank_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic por_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic high_voltage_mode = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  rpfcb_pkg::rpfcb_cfg_t power_fail_config;
  rpfcb_pkg::rpfcb_switcher_t switcher_enable;
  rpfcb_pkg::rpfcb_level_t active_level;
  logic [31:0] rd;
  logic [3:0] c4;
  logic [7:0] lvl;
  logic [11:0] ofs [4] = '{12'h510, 12'h704, 12'h904, 12'hb00};
  int err_total = 0;
  int checks = 0;

  // Word size is fixed, so hsize is tied to a constant; hready is tied back to hreadyout
  rpfcb_bank rpfcb_bank_inst (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .high_voltage_mode, .power_fail_config, .switcher_enable, .active_level);

  initial begin
    forever #10 hclk = ~hclk;
  end

  // ----------------
  // Bus tasks
  // ----------------
  task conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      n++;
      @(posedge hclk);
    end
    if (hreadyout !== 1'b1) begin
      err_total++;
      conclude();
    end
  endtask

  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    htrans <= rpfcb_pkg::HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  // ----------------
  // Tests
  // ----------------
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(ofs[i], 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    $display("done: reset values");
    xfer(ofs[0], 1'b1, 32'hffff_ffff);
    xfer(ofs[0], 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0f1f);
    chk({23'h0, power_fail_config}, 32'h0000_01ff);
    // Enables set one after another show the ones not yet written stay linear
    for (int i = 1; i < 4; i++) begin
      xfer(ofs[i], 1'b1, 32'hffff_ffff);
      xfer(ofs[i], 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      chk({29'h0, switcher_enable}, (32'h1 << i) - 32'h1);
    end
    // Clearing one enable returns only that regulator to linear
    xfer(ofs[2], 1'b1, 32'hffff_fffe);
    xfer(ofs[2], 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({29'h0, switcher_enable}, 32'h0000_0005);
    xfer(ofs[2], 1'b1, 32'h0000_0001);
    xfer(12'h700, 1'b1, 32'hffff_ffff);
    xfer(12'h700, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    xfer(ofs[1], 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    $display("done: layout and switchers");
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 16; c++) begin
        c4 = c[3:0];
        high_voltage_mode <= m[0];
        lvl = m[0] ? {c4[0], 1'b1, 6'h1b + {2'h0, ~c4}} : {c4[0], c4 >= 4'h6, 6'h0d + {2'h0, c4}};
        xfer(ofs[0], 1'b1, {20'h0_0000, ~c4, 3'h0, c4, c4[0]});
        @(posedge hclk);
        #1;
        chk({24'h0, active_level}, {24'h0, lvl});
      end
    end
    $display("done: warning levels");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(ofs[0], 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_001f);
    for (int i = 1; i < 4; i++) begin
      xfer(ofs[i], 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
    end
    $display("done: retention");
    @(posedge hclk);
    por_n <= 1'b0;
    repeat (3) @(posedge hclk);
    por_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(ofs[i], 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    $display("done: power-on clear");
    conclude();
  end
endmodule
